// ===== uart_mls_defines.svh
// Offsets, bit positions, reset values and sizes for the modem/line status block
`ifndef UART_MLS_DEFINES_SVH
`define UART_MLS_DEFINES_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define MLS_OFF_DATA 8'h00
`define MLS_OFF_IRQ_EN 8'h04
`define MLS_OFF_MODE 8'h08
`define MLS_OFF_HSK_CTRL 8'h0C
`define MLS_OFF_EXT_ONE 8'h10
`define MLS_OFF_LINE 8'h14
`define MLS_OFF_HSK_IN 8'h18
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define MLS_HC_DTR 0
`define MLS_HC_RTS 1
`define MLS_HC_B2 2
`define MLS_HC_B3 3
`define MLS_HC_LOOP 4
`define MLS_EXT_LOOP 4
`define MLS_MODE_EXT 0
`define MLS_MODE_FIFO 1
`define MLS_MODE_RXSR 2
`define MLS_IE_RLS 2
`define MLS_IE_HSK 3
// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define MLS_LINE_RESET 8'h60
`define MLS_RX_DEPTH 5'h10
`define MLS_RX_HOLD 5'h01
`endif

// ===== uart_mls_pkg.sv
// Types shared by the modem/line status block
package uart_mls_pkg;
    // Operating mode of the port
    typedef enum logic {
        MODE_LEGACY,
        MODE_EXTENDED
    } uart_mode_t;

    // One character from the receiver front end
    typedef struct packed {
        logic valid;            // One-cycle strobe
        logic line_break_flag;              // Break seen
        logic fe;               // Stop bit sampled 0
        logic pe;               // Parity mismatch
        logic [7:0] data;       // Character
    } rx_char_t;

    // Active-low handshake inputs: [0] cts, [1] dsr, [2] ri, [3] dcd
    typedef struct packed {
        logic [3:0] n;
    } hsk_pins_t;

    // Receive slot: error tags with the character
    typedef struct packed {
        logic line_break_flag;
        logic fe;
        logic pe;
        logic [7:0] data;
    } rx_slot_t;

    // Whole state of the block apart from the two reset release flops
    typedef struct packed {
        rx_slot_t [15:0] mem;   // Receive store
        logic [3:0] rd_ptr;
        logic [3:0] wr_ptr;
        logic [4:0] count;
        logic head_seen;        // Bottom character tags already shown
        logic brk_hold;         // Swallow break chars until a good one
        logic [4:1] sticky;     // oe, pe, fe, brk
        logic er;               // Tagged char entered the FIFO
        logic dtr_n;
        logic rts_n;
        logic b2;
        logic b3;
        logic loop;
        logic defer_en;
        uart_mode_t mode;
        logic fifo_en;
        logic rls_ie;
        logic hsk_ie;
        logic [3:0] delta;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] prev;
        logic [7:0] tx_hold;
        logic tx_full;
        logic defer;
        logic irq;
        logic rls_ev;
        logic hsk_ev;
        logic pready;
        logic pslverr;
        logic [7:0] prdata;
        logic [4:1] lsr_cap;
        logic er_cap;
        logic [3:0] msr_cap;
    } state_t;
endpackage

// ===== uart_modem_line_status.sv
// Modem control, line status and modem status logic with APB register access
//
// Overview of operation
// R1 - Control bits drive active-low dtr/rts pins
// R2 - Legacy loopback: dtr,rts,b2,b3 feed dsr,cts,ri,dcd
// R3 - Legacy, no loop: irq gated by bit 3
// R4 - Loop bit shared by both control registers
// R5 - Extended: irq always on, loop via ext reg
// R6 - Extended loop: dtr->dsr,ri; rts->cts,dcd
// R7 - Extended bit 3 defers tx with FIFO on
// R8 - Line bits 1-4 sticky, clear on read/reset
// R9 - Line status resets to 0x60, read only
// R10 - Line errors raise event when enabled
// R11 - Data available while receive store nonempty
// R12 - Overrun sets at once, new char dropped
// R13 - Parity error travels with its character
// R14 - Framing error travels with its character
// R15 - After framing error accept next start
// R16 - Break stores one zero, then waits
// R17 - Holding free set empty, cleared by write
// R18 - Transmitter idle needs shifter idle too
// R19 - FIFO error summary, zero with FIFO off
// R20 - Modem deltas clear on read, raise event
// R21 - cts/dsr any edge; ring trailing edge only
// R22 - Loopback disconnects pins, feeds from control
// R23 - Status 7:4 inverted pin levels, dcd delta
// R24 - Pins synchronised before edge detection
//
// Register access over APB and the placing of the registers are this design's own decisions.
`include "uart_mls_defines.svh"

module uart_modem_line_status
    import uart_mls_pkg::*;
(
    input wire logic clk_sys_i,      // Core clock, 25 MHz
    input wire logic rstn_i,         // Async reset, active low
    input wire logic psel_i,         // APB select
    input wire logic penable_i,      // APB enable
    input wire logic pwrite_i,       // APB direction
    input wire logic [7:0] paddr_i,  // APB byte address
    input wire logic [31:0] pwdata_i, // APB write data
    output logic [31:0] prdata_o,    // APB read data
    output logic pready_o,           // APB ready
    output logic pslverr_o,          // APB error, unmapped address
    input wire rx_char_t rx_char_i,  // Finished character from receiver
    input wire logic tx_take_i,      // Shifter takes the held char
    input wire logic tx_busy_i,      // Shifter front end busy
    output logic [7:0] tx_data_o,    // Held transmit character
    output logic tx_valid_o,         // Transmit character held
    output logic tx_defer_o,         // Transmission deferral active
    input wire hsk_pins_t hsk_pins_i, // Active-low modem inputs
    output logic dtr_n_o,            // Terminal ready, active low
    output logic rts_n_o,            // Send request, active low
    input wire logic irq_src_i,      // Other port interrupt sources
    output logic irq_o,              // Gated interrupt request
    output logic rls_event_o,        // Receiver line status event
    output logic hsk_event_o         // Modem status event
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_s1_q; // First stage, read only by the second
    logic rst_s2_q; // Released reset used by the block

    // Two flops so release never lands near a clock edge
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam state_t ST_RST = '{dtr_n: 1'b1, rts_n: 1'b1, sync1: 4'hF, sync2: 4'hF,
        mode: MODE_LEGACY, default: '0};

    state_t st_q; // Registered state
    state_t st_d; // Next state
    logic [3:0] lvl; // Internal active-high modem levels
    logic [7:0] lsr_val; // Line status as read
    logic [7:0] rd_val; // Read mux result
    logic hit; // Address decodes
    logic acc; // Access phase
    logic done; // Transfer completes this edge
    logic pop; // Receive char read out
    logic [4:0] cap; // Receive store capacity
    rx_slot_t head; // Bottom receive slot

    // Capacity follows the FIFO enable: one holding slot otherwise
    function automatic logic [4:0] rx_cap(input logic fifo);
        rx_cap = fifo ? `MLS_RX_DEPTH : `MLS_RX_HOLD;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        acc = psel_i & penable_i;
        done = acc & st_q.pready;
        cap = rx_cap(st_q.fifo_en);
        head = st_q.mem[st_q.rd_ptr];
        pop = 1'b0;

        // Pins pass two flops before any edge logic
        st_d.sync1 = hsk_pins_i.n; // see R24
        st_d.sync2 = st_q.sync1; // see R24

        // Loopback replaces the pins with control bits
        if (!st_q.loop) begin
            lvl = ~st_q.sync2; // see R23
        end else if (st_q.mode == MODE_EXTENDED) begin
            lvl = {~st_q.rts_n, ~st_q.dtr_n, ~st_q.dtr_n, ~st_q.rts_n}; // see R6, R22
        end else begin
            lvl = {st_q.b3, st_q.b2, ~st_q.dtr_n, ~st_q.rts_n}; // see R2, R22
        end
        st_d.prev = lvl;

        // Line status view; summary only with FIFOs on
        lsr_val = {st_q.er & st_q.fifo_en, // see R19
            ~st_q.tx_full & ~tx_busy_i, // see R18
            ~st_q.tx_full, // see R17
            st_q.sticky, // see R8
            st_q.count != 5'h00}; // see R11

        // Register read mux
        hit = 1'b1;
        case (paddr_i)
            `MLS_OFF_DATA: begin
                rd_val = head.data;
            end
            `MLS_OFF_IRQ_EN: begin
                rd_val = {4'h0, st_q.hsk_ie, st_q.rls_ie, 2'h0};
            end
            `MLS_OFF_MODE: begin
                rd_val = {6'h00, st_q.fifo_en, st_q.mode == MODE_EXTENDED};
            end
            `MLS_OFF_HSK_CTRL: begin
                if (st_q.mode == MODE_EXTENDED) begin
                    // Bit 2 and bits 7:4 read zero
                    rd_val = {4'h0, st_q.defer_en, 1'b0, ~st_q.rts_n, ~st_q.dtr_n}; // see R6, R7
                end else begin
                    rd_val = {3'h0, st_q.loop, st_q.b3, st_q.b2, ~st_q.rts_n, ~st_q.dtr_n};
                end
            end
            `MLS_OFF_EXT_ONE: begin
                rd_val = {3'h0, st_q.loop, 4'h0}; // see R4
            end
            `MLS_OFF_LINE: begin
                rd_val = lsr_val;
            end
            `MLS_OFF_HSK_IN: begin
                rd_val = {lvl, st_q.delta}; // see R23
            end
            default: begin
                rd_val = 8'h00;
                hit = 1'b0;
            end
        endcase

        // APB: one wait state, data captured on the first access edge
        if (acc & !st_q.pready) begin
            st_d.pready = 1'b1;
            st_d.prdata = rd_val;
            st_d.pslverr = ~hit;
            // Remember exactly what was shown so later events survive the clear
            st_d.lsr_cap = (!pwrite_i && paddr_i == `MLS_OFF_LINE) ? st_q.sticky : 4'h0;
            st_d.er_cap = !pwrite_i && paddr_i == `MLS_OFF_LINE && st_q.er;
            st_d.msr_cap = (!pwrite_i && paddr_i == `MLS_OFF_HSK_IN) ? st_q.delta : 4'h0;
        end else begin
            st_d.pready = 1'b0;
            st_d.pslverr = 1'b0;
        end

        // Transmit hand-off to the shifter
        if (tx_take_i & st_q.tx_full) begin
            st_d.tx_full = 1'b0; // see R17
        end

        // Effects of a completed transfer
        if (done & !pwrite_i) begin
            case (paddr_i)
                `MLS_OFF_LINE: begin
                    st_d.sticky = st_q.sticky & ~st_q.lsr_cap; // see R8
                    st_d.er = st_q.er & ~st_q.er_cap; // see R19
                end
                `MLS_OFF_HSK_IN: begin
                    st_d.delta = st_q.delta & ~st_q.msr_cap; // see R20
                end
                `MLS_OFF_DATA: begin
                    pop = st_q.count != 5'h00; // see R11
                end
                default: begin
                end
            endcase
        end else if (done & pwrite_i) begin
            case (paddr_i)
                `MLS_OFF_DATA: begin
                    // Writing the data register fills the holding slot
                    st_d.tx_hold = pwdata_i[7:0];
                    st_d.tx_full = 1'b1; // see R17
                end
                `MLS_OFF_IRQ_EN: begin
                    st_d.rls_ie = pwdata_i[`MLS_IE_RLS];
                    st_d.hsk_ie = pwdata_i[`MLS_IE_HSK];
                end
                `MLS_OFF_MODE: begin
                    st_d.mode = pwdata_i[`MLS_MODE_EXT] ? MODE_EXTENDED : MODE_LEGACY;
                    st_d.fifo_en = pwdata_i[`MLS_MODE_FIFO];
                end
                `MLS_OFF_HSK_CTRL: begin
                    st_d.dtr_n = ~pwdata_i[`MLS_HC_DTR]; // see R1
                    st_d.rts_n = ~pwdata_i[`MLS_HC_RTS]; // see R1
                    if (st_q.mode == MODE_EXTENDED) begin
                        // Loop is not reachable from here in extended mode
                        st_d.defer_en = pwdata_i[`MLS_HC_B3]; // see R5, R7
                    end else begin
                        st_d.b2 = pwdata_i[`MLS_HC_B2];
                        st_d.b3 = pwdata_i[`MLS_HC_B3];
                        st_d.loop = pwdata_i[`MLS_HC_LOOP]; // see R4
                    end
                end
                `MLS_OFF_EXT_ONE: begin
                    st_d.loop = pwdata_i[`MLS_EXT_LOOP]; // see R4, R5
                end
                default: begin
                    // Line and modem status ignore writes
                end
            endcase
        end

        // Pop the bottom character; its tags are then done with
        if (pop) begin
            st_d.rd_ptr = st_q.rd_ptr + 4'h1;
            st_d.count = st_q.count - 5'h01;
            st_d.head_seen = 1'b0;
        end

        // Receiver soft reset, or a FIFO enable change, empties the store
        if ((done & pwrite_i & paddr_i == `MLS_OFF_MODE) &&
            (pwdata_i[`MLS_MODE_RXSR] || pwdata_i[`MLS_MODE_FIFO] != st_q.fifo_en)) begin
            st_d.rd_ptr = 4'h0;
            st_d.wr_ptr = 4'h0;
            st_d.count = 5'h00;
            st_d.head_seen = 1'b0;
            st_d.brk_hold = 1'b0;
            st_d.er = 1'b0;
            if (pwdata_i[`MLS_MODE_RXSR]) begin
                st_d.sticky = 4'h0; // see R8
            end
        end else if (rx_char_i.valid) begin
            if (rx_char_i.line_break_flag & st_q.brk_hold) begin
                // Line still low: no second zero char
                st_d.brk_hold = 1'b1; // see R16
            end else if (st_q.count == cap) begin
                // Full: new char dropped, stored data untouched
                st_d.sticky[1] = 1'b1; // see R12
            end else begin
                // A char after a framing error is taken like any other
                st_d.mem[st_q.wr_ptr] = '{line_break_flag: rx_char_i.line_break_flag, fe: rx_char_i.fe,
                    pe: rx_char_i.pe, data: rx_char_i.line_break_flag ? 8'h00 : rx_char_i.data}; // see R15
                st_d.wr_ptr = st_q.wr_ptr + 4'h1;
                st_d.count = st_d.count + 5'h01;
                st_d.brk_hold = rx_char_i.line_break_flag; // see R16
                if (st_q.fifo_en & (rx_char_i.line_break_flag | rx_char_i.fe | rx_char_i.pe)) begin
                    st_d.er = 1'b1; // see R19
                end
            end
        end

        // Tags show only once their char is at the bottom
        if (st_q.count != 5'h00 && !st_q.head_seen && !pop) begin
            st_d.sticky[2] = st_d.sticky[2] | head.pe; // see R13
            st_d.sticky[3] = st_d.sticky[3] | head.fe; // see R14
            st_d.sticky[4] = st_d.sticky[4] | head.line_break_flag; // see R16
            st_d.head_seen = 1'b1;
        end

        // Modem deltas; set wins over a read clear in the same edge
        st_d.delta[0] = st_d.delta[0] | (lvl[0] ^ st_q.prev[0]); // see R21
        st_d.delta[1] = st_d.delta[1] | (lvl[1] ^ st_q.prev[1]); // see R21
        st_d.delta[2] = st_d.delta[2] | (st_q.prev[2] & ~lvl[2]); // see R21
        st_d.delta[3] = st_d.delta[3] | (lvl[3] ^ st_q.prev[3]); // see R23

        // Events and interrupt gate
        st_d.rls_ev = st_d.rls_ie & (|st_d.sticky); // see R10
        st_d.hsk_ev = st_d.hsk_ie & (|st_d.delta); // see R20
        st_d.irq = (st_d.mode == MODE_EXTENDED || st_d.loop || st_d.b3) &
            (st_d.rls_ev | st_d.hsk_ev | irq_src_i); // see R3, R5
        // Deferral counts only with the transmit FIFO running
        st_d.defer = st_d.mode == MODE_EXTENDED & st_d.defer_en & st_d.fifo_en; // see R7
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i or negedge rst_s2_q) begin
        if (!rst_s2_q) begin
            st_q <= ST_RST; // see R9
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all straight from state flops
    // ------------------------------------------------------------
    assign prdata_o = {24'h000000, st_q.prdata};
    assign pready_o = st_q.pready;
    assign pslverr_o = st_q.pslverr;
    assign tx_data_o = st_q.tx_hold;
    assign tx_valid_o = st_q.tx_full;
    assign tx_defer_o = st_q.defer;
    assign dtr_n_o = st_q.dtr_n;
    assign rts_n_o = st_q.rts_n;
    assign irq_o = st_q.irq;
    assign rls_event_o = st_q.rls_ev;
    assign hsk_event_o = st_q.hsk_ev;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_s2_q);

    logic wr_ctrl; // Completed control write, either mode
    assign wr_ctrl = done & pwrite_i & paddr_i == `MLS_OFF_HSK_CTRL;

    property p_dtr_pin;
        wr_ctrl |=> dtr_n_o == !$past(pwdata_i[0]) && rts_n_o == !$past(pwdata_i[1]);
    endproperty
    a_dtr_pin: assert property (p_dtr_pin) else $error("dtr/rts pin mismatch"); // see R1

    property p_gate;
        (st_q.mode == MODE_LEGACY && !st_q.loop && !st_q.b3) |-> !irq_o;
    endproperty
    a_gate: assert property (p_gate) else $error("irq not gated"); // see R3

    property p_ext_irq;
        (st_q.mode == MODE_EXTENDED && st_q.rls_ev) |-> irq_o;
    endproperty
    a_ext_irq: assert property (p_ext_irq) else $error("extended irq blocked"); // see R5

    property p_ext_loop;
        (st_q.loop && st_q.mode == MODE_EXTENDED) |-> lvl[2] == !dtr_n_o && lvl[3] == !rts_n_o;
    endproperty
    a_ext_loop: assert property (p_ext_loop) else $error("extended loop wiring"); // see R6

    sequence s_full_char;
        rx_char_i.valid && !rx_char_i.line_break_flag && st_q.count == cap && !pop && !wr_ctrl;
    endsequence
    property p_overrun;
        s_full_char ##1 !$past(psel_i) |-> st_q.sticky[1] && $stable(st_q.wr_ptr);
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun lost or stored"); // see R12

    property p_thr;
        (done && pwrite_i && paddr_i == `MLS_OFF_DATA) |=> !lsr_val[5] ##1 1;
    endproperty
    a_thr: assert property (p_thr) else $error("holding free after write"); // see R17

    property p_temt;
        lsr_val[6] |-> lsr_val[5] && !tx_busy_i;
    endproperty
    a_temt: assert property (p_temt) else $error("idle while busy"); // see R18

    property p_ri_edge;
        (st_q.prev[2] == 1'b0 && lvl[2] && st_q.delta[2] == 1'b0) |=> !st_q.delta[2];
    endproperty
    a_ri_edge: assert property (p_ri_edge) else $error("ring delta on leading edge"); // see R21

    property p_cts_delta;
        (lvl[0] != st_q.prev[0]) |=> st_q.delta[0];
    endproperty
    a_cts_delta: assert property (p_cts_delta) else $error("cts change missed"); // see R21

    property p_rx_data_available;
        lsr_val[0] == (st_q.count != 5'h00) && st_q.count <= cap;
    endproperty
    a_rx_data_available: assert property (p_rx_data_available) else $error("data available wrong"); // see R11

endmodule

// ===== modem_model.sv
// Modem side model driving the active-low handshake inputs
module modem_model
    import uart_mls_pkg::*;
(
    input wire logic clk_i,        // Core clock
    input wire logic [3:0] want_i, // Requested pin levels
    input wire logic slow_i,       // Late answer when high
    output hsk_pins_t pins_o       // Handshake pins
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_q = 0; // Cycles since a change was asked for
    // ----------------------------------------
    // Pin driver
    // ----------------------------------------
    // Lines idle inactive (high) so reset sees no change
    initial pins_o = '{n: 4'hF};
    // A real modem is not instant: answer after 2 or 8 cycles
    always @(posedge clk_i) begin
        if (want_i !== pins_o.n) begin
            wait_q <= wait_q + 1;
            if (wait_q >= (slow_i ? 7 : 1)) begin
                pins_o.n <= want_i;
                wait_q <= 0;
            end
        end
    end
endmodule

// ===== testbench.sv
// Self-checking bench for the modem control and status block
`include "uart_mls_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import uart_mls_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [7:0] A_DT = `MLS_OFF_DATA;
    localparam logic [7:0] A_IE = `MLS_OFF_IRQ_EN;
    localparam logic [7:0] A_MD = `MLS_OFF_MODE;
    localparam logic [7:0] A_HC = `MLS_OFF_HSK_CTRL;
    localparam logic [7:0] A_X1 = `MLS_OFF_EXT_ONE;
    localparam logic [7:0] A_LN = `MLS_OFF_LINE;
    localparam logic [7:0] A_HI = `MLS_OFF_HSK_IN;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pad = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic prdy;
    logic perr;
    logic err;
    rx_char_t rxc_v = '0;
    logic take = 1'b0;
    logic busy = 1'b0;
    logic isrc = 1'b0;
    logic [7:0] txd;
    logic txv, dfr, dtr_n, rts_n, irq, rls, hsk;
    hsk_pins_t pins;
    logic [3:0] want = 4'hF;
    logic slow = 1'b0;
    logic [31:0] rd;
    logic [3:0] pv, dl;
    logic [3:0] steps [6] = '{4'hE, 4'hC, 4'h8, 4'hC, 4'h4, 4'hF};
    logic [10:0] q [$]; // Expected receive store contents
    logic [10:0] v;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    always #20 clk = ~clk; // 25 MHz
    uart_modem_line_status dut (.clk_sys_i(clk), .rstn_i(rstn), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pad), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(prdy), .pslverr_o(perr), .rx_char_i(rxc_v), .tx_take_i(take),
        .tx_busy_i(busy), .tx_data_o(txd), .tx_valid_o(txv), .tx_defer_o(dfr),
        .hsk_pins_i(pins), .dtr_n_o(dtr_n), .rts_n_o(rts_n), .irq_src_i(isrc),
        .irq_o(irq), .rls_event_o(rls), .hsk_event_o(hsk));
    modem_model dce (.clk_i(clk), .want_i(want), .slow_i(slow), .pins_o(pins));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // One APB transfer; holds everything until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pad <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (prdy !== 1'b1);
        rd = prd;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e, input string m);
        apb(1'b0, a, 32'h0);
        chk(rd, e, m);
    endtask
    // One finished character, valid for a single cycle
    task automatic rx(input logic [10:0] c);
        @(posedge clk);
        rxc_v <= {1'b1, c};
        @(posedge clk);
        rxc_v <= '0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            results();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'hBFE4E6E9));
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        rdx(A_LN, 32'h60, "line reset");
        apb(1'b1, A_LN, 32'hFF);
        rdx(A_LN, 32'h60, "line write");
        apb(1'b0, 8'h1C, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped");
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, A_HC, i);
            repeat (2) @(posedge clk);
            chk({dtr_n, rts_n}, {~i[0], ~i[1]}, "pins");
        end
        // Gate bit decides the request in legacy mode; extended ignores it
        isrc <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, A_HC, (i % 2) * 8);
            apb(1'b1, A_MD, i / 2);
            repeat (2) @(posedge clk);
            chk(irq, (i != 0), "irq gate");
        end
        apb(1'b1, A_HC, 32'h1F);
        rdx(A_HC, 32'h0B, "ext ctrl");
        chk(dfr, 1'b0, "defer off");
        apb(1'b1, A_MD, 32'h3);
        repeat (2) @(posedge clk);
        chk(dfr, 1'b1, "defer on");
        apb(1'b1, A_MD, 32'h0);
        isrc <= 1'b0;
        apb(1'b1, A_HC, 32'h08);
        apb(1'b1, A_IE, 32'h0C);
        // Pin walk: deltas from any cts/dsr/dcd edge, ring only on rise
        pv = 4'hF;
        for (int i = 0; i < 6; i++) begin
            want <= steps[i];
            slow <= i[0];
            repeat (14) @(posedge clk);
            dl = ((pv ^ steps[i]) & 4'hB) | (steps[i] & ~pv & 4'h4);
            chk(hsk, (dl != 0), "hsk event");
            rdx(A_HI, {24'h0, ~steps[i], dl}, "hsk status");
            pv = steps[i];
        end
        // Legacy loopback: control bits replace the pins
        apb(1'b1, A_HC, 32'h1F);
        repeat (8) @(posedge clk);
        rdx(A_HI, 32'hFB, "loop legacy");
        chk({dtr_n, rts_n}, 2'b00, "loop pins");
        rdx(A_X1, 32'h10, "shared loop");
        want <= 4'h0;
        repeat (14) @(posedge clk);
        rdx(A_HI, 32'hF0, "pins ignored");
        isrc <= 1'b1;
        apb(1'b1, A_HC, 32'h17);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1, "loop irq");
        isrc <= 1'b0;
        apb(1'b1, A_MD, 32'h1);
        apb(1'b1, A_HC, 32'h01);
        repeat (8) @(posedge clk);
        rdx(A_HI, 32'h69, "loop ext");
        want <= 4'hF;
        apb(1'b1, A_X1, 32'h0);
        apb(1'b1, A_MD, 32'h0);
        // Transmit holding slot and front end
        apb(1'b1, A_DT, 32'hA5);
        repeat (2) @(posedge clk);
        chk({txv, txd}, 9'h1A5, "tx held");
        rdx(A_LN, 32'h00, "tx full");
        @(posedge clk);
        take <= 1'b1;
        busy <= 1'b1;
        @(posedge clk);
        take <= 1'b0;
        rdx(A_LN, 32'h20, "tx busy");
        busy <= 1'b0;
        rdx(A_LN, 32'h60, "tx idle");
        // Holding register overrun, FIFO off
        rx(11'h041);
        rx(11'h042);
        rdx(A_LN, 32'h63, "overrun");
        rdx(A_LN, 32'h61, "sticky clr");
        rdx(A_DT, 32'h41, "kept char");
        rdx(A_LN, 32'h60, "empty");
        // Error tags with FIFO on: parity, framing, break
        apb(1'b1, A_MD, 32'h2);
        for (int k = 0; k < 3; k++) begin
            v = (k == 2) ? 11'h400 : ((11'h100 << k) | 11'($urandom_range(0, 255)));
            rx(v);
            repeat (3) @(posedge clk);
            chk(rls, 1'b1, "rls event");
            rdx(A_LN, 32'hE1 | (32'h4 << k), "tagged");
            rdx(A_DT, v[7:0], "tag data");
            rdx(A_LN, 32'h60, "tag clr");
        end
        rx(11'h400);
        rdx(A_LN, 32'h60, "brk again");
        rx(11'h100);
        apb(1'b1, A_MD, 32'h6);
        rdx(A_LN, 32'h60, "soft reset");
        // Fill the FIFO with random data, one beyond capacity
        for (int i = 0; i < 17; i++) begin
            v = 11'($urandom_range(0, 255));
            rx(v);
            if (i < 16) q.push_back(v);
        end
        rdx(A_LN, 32'h63, "fifo full");
        while (q.size() > 0) rdx(A_DT, q.pop_front(), "fifo data");
        rdx(A_LN, 32'h60, "drained");
        results();
    end
endmodule
